// ==== logic/dccu_top.sv ====
/*
  dccu_top: two capture/compare/PWM channels with an Avalon-MM register slave.
  Assumes the 16-bit wide timer and the 10-bit period timer live outside;
  their counts arrive on ref_clk, the capture pins arrive asynchronously.

  // Operation
  // R1: capture copies full 16-bit timer count
  // R2: falling, rising, 4th, 16th rising edge
  // R3: capture sets flag, software clears it
  // R4: new capture overwrites unread value
  // R5: port write on output pin can capture
  // R6: mode change may set flag spuriously
  // R7: prescaler held zero outside capture modes
  // R8: reset clears both prescaler counters
  // R9: prescale change keeps prescaler count
  // R10: compare register against timer continuously
  // R11: match sets, clears or keeps pin, flags
  // R12: cleared control forces compare latch low
  // R13: mode field encodes off, capture, compare, pwm
  // R14: software-flag mode leaves pin untouched
  // R15: channel one trigger resets wide timer
  // R16: channel two trigger also starts conversion
  // R17: trigger reset never sets overflow flag
  // R18: control bits 5:4 are duty lsbs
  // R19: pwm uses period timer, others wide timer
  // R20: software keeps wide timer synchronous for capture
  // R21: software keeps wide timer synchronous for compare
  // R22: two-flop synchroniser before edge detection
*/
`timescale 1ns/1ps
`default_nettype none

module dccu_top
  import dccu_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // time bases
  input  wire logic [15:0] wide_timer_count,
  input  wire logic        wide_timer_tick,
  input  wire logic [9:0]  period_timer_count,
  input  wire logic        period_timer_wrap,
  // channel pins
  input  wire logic [1:0]  channel_pin_in,
  output logic      [1:0]  channel_pin_out,
  output logic      [1:0]  channel_pin_oe_n,
  // system side
  input  wire logic        adc_enabled,
  output logic             wide_timer_reset,
  output logic             adc_go,
  output logic      [1:0]  channel_flag
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [5:0]  ctrl_ff     [2];
  logic [7:0]  low_ff      [2];
  logic [7:0]  high_ff     [2];
  logic [1:0]  duty_lsb_ff [2];
  logic [1:0]  flag_ff;
  logic [1:0]  irq_en_ff;
  logic [1:0]  port_dir_ff;
  logic [1:0]  port_data_ff;
  logic [1:0]  sync1_ff;
  logic [1:0]  sync2_ff;
  logic [1:0]  pin_prev_ff;
  logic [3:0]  psc_ff      [2];
  logic [1:0]  cmp_latch_ff;
  logic [1:0]  pwm_out_ff;
  dccu_bus_t   bus_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  resp_ff;
  logic        wait_ff;
  logic        trig_ff;
  logic        go_ff;
  dccu_evt_t   evt [2];

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire       req       = (avs_read | avs_write) & (bus_ff == DCCU_IDLE);
  wire [7:0] idx       = avs_address[9:2];
  wire       wr_go     = (bus_ff == DCCU_ANS) & avs_write & avs_byteenable[0];
  wire       hit_c1    = (idx == CH1_CTRL_IDX);
  wire       hit_c2    = (idx == CH2_CTRL_IDX);
  wire       hit_l1    = (idx == CH1_LOW_IDX);
  wire       hit_h1    = (idx == CH1_HIGH_IDX);
  wire       hit_l2    = (idx == CH2_LOW_IDX);
  wire       hit_h2    = (idx == CH2_HIGH_IDX);
  wire       hit_fl    = (idx == FLAGS_IDX);
  wire       hit_ie    = (idx == IRQ_EN_IDX);
  wire       hit_pt    = (idx == PORT_IDX);
  wire       hit_st    = (idx == STATUS_IDX);
  wire       mapped    = hit_c1 | hit_c2 | hit_l1 | hit_h1 | hit_l2 | hit_h2 |
                         hit_fl | hit_ie | hit_pt | hit_st;
  wire [1:0] wr_ctrl   = {wr_go & hit_c2, wr_go & hit_c1};
  wire [1:0] wr_low    = {wr_go & hit_l2, wr_go & hit_l1};
  wire [1:0] wr_high   = {wr_go & hit_h2, wr_go & hit_h1};
  wire       wr_flag   = wr_go & hit_fl;
  wire       wr_ie     = wr_go & hit_ie;
  wire       wr_port   = wr_go & hit_pt;

  // pin level seen by the capture logic: synchronised pin input, also when output
  wire [1:0] pin_level = sync2_ff;

  wire [31:0] rd_mux =
      hit_c1 ? {24'h0, 2'h0, duty_lsb_ff[0], ctrl_ff[0][3:0]} :
      hit_c2 ? {24'h0, 2'h0, duty_lsb_ff[1], ctrl_ff[1][3:0]} :
      hit_l1 ? {24'h0, low_ff[0]} :
      hit_h1 ? {24'h0, high_ff[0]} :
      hit_l2 ? {24'h0, low_ff[1]} :
      hit_h2 ? {24'h0, high_ff[1]} :
      hit_fl ? {30'h0, flag_ff} :
      hit_ie ? {30'h0, irq_en_ff} :
      hit_pt ? {28'h0, port_dir_ff, port_data_ff} :
      hit_st ? {28'h0, pin_level, cmp_latch_ff} : 32'h0;

  // ---------------------------------------------------------------
  // per-channel logic
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      wire [3:0] mode     = ctrl_ff[g][3:0];
      wire       is_cap   = (mode[3:2] == 2'b01);                          // [R13]
      wire       is_cmp   = (mode[3:2] == 2'b10);                          // [R13]
      wire       is_pwm   = (mode[3:2] == 2'b11);                          // [R13]
      wire       rise     = pin_level[g] & ~pin_prev_ff[g];                // [R22]
      wire       fall     = ~pin_level[g] & pin_prev_ff[g];                // [R22]
      wire [3:0] psc_inc  = psc_ff[g] + 4'h1;
      wire       psc_done = (mode == DCCU_CAP_4TH)  ? (psc_ff[g][1:0] == PRESCALE_4) :
                            (mode == DCCU_CAP_16TH) ? (psc_ff[g] == PRESCALE_16) : 1'b1;
      // fall for code 4, rise for others, prescaled 4th/16th
      wire       cap_edge = is_cap & ((mode == DCCU_CAP_FALL) ? fall : rise); // [R2]
      wire       capture  = cap_edge & psc_done;                           // [R2]
      // equality checked on each timer update
      wire       match    = is_cmp & wide_timer_tick &
                            ({high_ff[g], low_ff[g]} == wide_timer_count);  // [R10] [R19]
      wire [9:0] duty     = {low_ff[g], duty_lsb_ff[g]};                    // [R18]
      wire [9:0] duty_act = {high_ff[g], 2'h0} | {8'h0, duty_lsb_ff[g]};

      assign evt[g] = '{capture: capture, match: match, trigger: match & (mode == DCCU_CMP_TRIG)};

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          psc_ff[g] <= 4'h0;                                               // [R8]
        end else if (!is_cap) begin
          psc_ff[g] <= 4'h0;                                               // [R7]
        end else if (cap_edge) begin
          // a capture-mode change does not clear the count
          psc_ff[g] <= capture ? 4'h0 : psc_inc;                           // [R9]
        end
      end

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          low_ff[g]  <= 8'h00;
          high_ff[g] <= 8'h00;
        end else if (capture) begin
          // unread value is simply overwritten
          {high_ff[g], low_ff[g]} <= wide_timer_count;                     // [R1] [R4]
        end else begin
          if (wr_low[g]) begin
            low_ff[g] <= avs_writedata[7:0];
          end
          if (is_pwm & period_timer_wrap) begin
            high_ff[g] <= low_ff[g];
          end else if (wr_high[g] & ~is_pwm) begin
            high_ff[g] <= avs_writedata[7:0];
          end
        end
      end

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmp_latch_ff[g] <= 1'b0;
        end else if (ctrl_ff[g] == CTRL_RESET[5:0]) begin
          cmp_latch_ff[g] <= 1'b0;                                         // [R12]
        end else if (match & (mode == DCCU_CMP_SET)) begin
          cmp_latch_ff[g] <= 1'b1;                                         // [R11]
        end else if (match & (mode == DCCU_CMP_CLR)) begin
          cmp_latch_ff[g] <= 1'b0;                                         // [R11] [R14]
        end
      end

      // pwm on the period timer: set at wrap unless zero duty, clear at duty
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pwm_out_ff[g] <= 1'b0;
        end else if (!is_pwm) begin
          pwm_out_ff[g] <= 1'b0;
        end else if (period_timer_wrap) begin
          pwm_out_ff[g] <= (duty != 10'h0);                                // [R19]
        end else if (period_timer_count == duty_act) begin
          pwm_out_ff[g] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          channel_pin_out[g]  <= 1'b0;
          channel_pin_oe_n[g] <= 1'b1;
        end else begin
          channel_pin_oe_n[g] <= port_dir_ff[g];
          channel_pin_out[g]  <= is_pwm ? pwm_out_ff[g] :
                                 is_cmp ? cmp_latch_ff[g] : port_data_ff[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // control, flags and pins
  // ---------------------------------------------------------------
  wire [1:0] hw_set = {evt[1].capture | evt[1].match,
                       evt[0].capture | evt[0].match};                     // [R3] [R11]

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff[0]     <= CTRL_RESET[5:0];
      ctrl_ff[1]     <= CTRL_RESET[5:0];
      duty_lsb_ff[0] <= 2'h0;
      duty_lsb_ff[1] <= 2'h0;
    end else begin
      // mode change may raise a capture flag, left to software
      if (wr_ctrl[0]) begin
        ctrl_ff[0]     <= avs_writedata[5:0] & CTRL_WMASK;                 // [R6]
        duty_lsb_ff[0] <= avs_writedata[DUTY_LSB+1:DUTY_LSB];              // [R18]
      end
      if (wr_ctrl[1]) begin
        ctrl_ff[1]     <= avs_writedata[5:0] & CTRL_WMASK;
        duty_lsb_ff[1] <= avs_writedata[DUTY_LSB+1:DUTY_LSB];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_ff <= 2'h0;
    end else begin
      // write 1 clears; a same-cycle event wins
      flag_ff <= (flag_ff & ~({2{wr_flag}} & avs_writedata[1:0])) | hw_set; // [R3]
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_ff    <= 2'h0;
      port_dir_ff  <= 2'h3;
      port_data_ff <= 2'h0;
    end else begin
      if (wr_ie) begin
        irq_en_ff <= avs_writedata[1:0];
      end
      if (wr_port) begin
        port_data_ff <= avs_writedata[1:0];
        port_dir_ff  <= avs_writedata[3:2];
      end
    end
  end

  // pin returns via synchroniser even when driven, so port writes capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff    <= 2'h0;
      sync2_ff    <= 2'h0;
      pin_prev_ff <= 2'h0;
    end else begin
      sync1_ff    <= channel_pin_in;                                       // [R22] [R5]
      sync2_ff    <= sync1_ff;                                             // [R22]
      pin_prev_ff <= sync2_ff;
    end
  end

  // trigger resets the wide timer, channel two's also starts conversion; no overflow flag path here
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_ff      <= 1'b0;
      go_ff        <= 1'b0;
      channel_flag <= 2'h0;
    end else begin
      trig_ff      <= evt[0].trigger | evt[1].trigger;                     // [R15] [R16] [R17]
      go_ff        <= evt[1].trigger & adc_enabled;                        // [R16]
      channel_flag <= flag_ff;
    end
  end

  assign wide_timer_reset = trig_ff;
  assign adc_go           = go_ff;

  // ---------------------------------------------------------------
  // avalon answer: one wait cycle, answer on the second
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ff   <= DCCU_IDLE;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
      resp_ff  <= 2'h0;
    end else if (req) begin
      bus_ff   <= DCCU_ANS;
      wait_ff  <= 1'b0;
      rdata_ff <= avs_read ? rd_mux : 32'h0;
      resp_ff  <= mapped ? 2'h0 : 2'h3;
    end else begin
      bus_ff   <= DCCU_IDLE;
      wait_ff  <= 1'b1;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign avs_response    = resp_ff;

endmodule : dccu_top

`default_nettype wire

// ==== shared/dccu_pkg.sv ====
/*
  dccu_pkg: constants, types and register map of the dual capture/compare unit.
  Assumes a 32-bit Avalon-MM register bus with byte addressing.
*/
package dccu_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address divided by four
  // ---------------------------------------------------------------
  localparam logic [7:0] CH1_CTRL_IDX  = 8'h17;
  localparam logic [7:0] CH2_CTRL_IDX  = 8'h1d;
  localparam logic [7:0] CH1_LOW_IDX   = 8'h15;
  localparam logic [7:0] CH1_HIGH_IDX  = 8'h16;
  localparam logic [7:0] CH2_LOW_IDX   = 8'h1b;
  localparam logic [7:0] CH2_HIGH_IDX  = 8'h1c;
  localparam logic [7:0] FLAGS_IDX     = 8'h20;
  localparam logic [7:0] IRQ_EN_IDX    = 8'h21;
  localparam logic [7:0] PORT_IDX      = 8'h22;
  localparam logic [7:0] STATUS_IDX    = 8'h23;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int         MODE_LSB      = 0;
  localparam int         DUTY_LSB      = 4;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [5:0] CTRL_WMASK    = 6'h3f;
  localparam logic [3:0] PRESCALE_16   = 4'hf;
  localparam logic [1:0] PRESCALE_4    = 2'h3;

  // mode field encodings
  typedef enum logic [3:0] {
    DCCU_OFF      = 4'h0,
    DCCU_CAP_FALL = 4'h4,
    DCCU_CAP_RISE = 4'h5,
    DCCU_CAP_4TH  = 4'h6,
    DCCU_CAP_16TH = 4'h7,
    DCCU_CMP_SET  = 4'h8,
    DCCU_CMP_CLR  = 4'h9,
    DCCU_CMP_SOFT = 4'ha,
    DCCU_CMP_TRIG = 4'hb
  } dccu_mode_t;

  // bus slave states, gray along idle -> answer
  typedef enum logic [1:0] {
    DCCU_IDLE = 2'b00,
    DCCU_ANS  = 2'b01
  } dccu_bus_t;

  // per-channel timer-facing events
  typedef struct packed {
    logic       capture;
    logic       match;
    logic       trigger;
  } dccu_evt_t;

endpackage : dccu_pkg

// ==== dv/dccu_top_props.sv ====
/*
  dccu_chk: concurrent checks on the ports of dccu_top.
  Assumes one clock domain, ref_clk, with sys_rst as its reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dccu_chk
  import dccu_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // timer and system side
  input wire logic        wide_timer_tick,
  input wire logic        adc_enabled,
  input wire logic        wide_timer_reset,
  input wire logic        adc_go,
  input wire logic [1:0]  channel_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_ack_next_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer not one cycle after request");
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_decode_err: assert property (!avs_waitrequest && avs_address[9:2] > 8'h23 |-> avs_response == 2'h3)
    else $error("unmapped access without decode error");
  a_high_bits_zero: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_flag_sw_clear: assert property ($fell(channel_flag[0]) |-> $past(avs_write && avs_address[9:2] == FLAGS_IDX, 2))
    else $error("flag cleared without a software write");
  a_trig_single_pulse: assert property (wide_timer_reset |=> !wide_timer_reset)
    else $error("timer reset longer than one cycle");
  a_go_with_reset: assert property (adc_go |-> wide_timer_reset)
    else $error("conversion start without timer reset");
  a_go_needs_enable: assert property (adc_go |-> $past(adc_enabled) || $past(adc_enabled, 2))
    else $error("conversion start while converter disabled");
  a_reset_after_tick: assert property (wide_timer_reset |-> $past(wide_timer_tick) || $past(wide_timer_tick, 2))
    else $error("timer reset without a timer update");
endmodule : dccu_chk

`default_nettype wire

// ==== dv/dccu_far_model.sv ====
/*
  dccu_far_model: wide timer, period timer and pin wires facing the unit.
  Assumes every timer counts on ref_clk; nothing counts asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

module dccu_far_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // testbench control
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic [1:0]  ext_pin,
  // unit side
  input  wire logic        wide_timer_reset,
  input  wire logic [1:0]  channel_pin_out,
  input  wire logic [1:0]  channel_pin_oe_n,
  output logic      [15:0] wide_timer_count,
  output logic             wide_timer_tick,
  output logic      [9:0]  period_timer_count,
  output logic             period_timer_wrap,
  output logic      [1:0]  channel_pin_in
);
  // wire level: the unit wins while it drives
  assign channel_pin_in    = (channel_pin_oe_n & ext_pin) | (~channel_pin_oe_n & channel_pin_out);
  assign period_timer_wrap = &period_timer_count;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wide_timer_count   <= 16'h0000;
      wide_timer_tick    <= 1'b0;
      period_timer_count <= 10'h000;
    end else begin
      wide_timer_tick    <= run | load | wide_timer_reset;
      period_timer_count <= period_timer_count + 10'h001;
      if (wide_timer_reset)
        wide_timer_count <= 16'h0000;
      else if (load)
        wide_timer_count <= load_val;
      else if (run)
        wide_timer_count <= wide_timer_count + 16'h0001;
    end
  end
endmodule : dccu_far_model

`default_nettype wire

// ==== dv/tb_dccu_top.sv ====
/*
  tb_dccu_top: self-checking bench for dccu_top with the far-side model.
  Assumes the checker module dccu_chk is compiled beforehand.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_dccu_top;
  import dccu_pkg::*;
  logic        ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, wide_timer_tick;
  logic        period_timer_wrap, adc_enabled, wide_timer_reset, adc_go, run, load;
  logic [9:0]  avs_address, period_timer_count;
  logic [31:0] avs_writedata, avs_readdata, v;
  logic [3:0]  avs_byteenable;
  logic [15:0] wide_timer_count, load_val;
  logic [1:0]  avs_response, channel_pin_in, channel_pin_out, channel_pin_oe_n, channel_flag, ext_pin;
  logic [63:0] exp_q[$];
  logic [3:0]  cmp_mode[4] = '{DCCU_CMP_SET, DCCU_CMP_CLR, DCCU_CMP_SET, DCCU_CMP_SOFT};
  int          err_count, n_compared, seed, go_n, rst_n, g0, r0, nedge;
  logic        idle;

  dccu_top dccu_top_i (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .wide_timer_count,
    .wide_timer_tick, .period_timer_count, .period_timer_wrap, .channel_pin_in, .channel_pin_out,
    .channel_pin_oe_n, .adc_enabled, .wide_timer_reset, .adc_go, .channel_flag);
  dccu_far_model dccu_far_model_i (.ref_clk, .sys_rst, .run, .load, .load_val, .ext_pin,
    .wide_timer_reset, .channel_pin_out, .channel_pin_oe_n, .wide_timer_count, .wide_timer_tick,
    .period_timer_count, .period_timer_wrap, .channel_pin_in);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    exp_q.push_back({24'h0, m, 24'h0, e});
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask : rd

  task automatic pin(input logic lvl);
    @(posedge ref_clk);
    ext_pin <= {1'b0, lvl};
    repeat (6) @(posedge ref_clk);
  endtask : pin

  task automatic tload(input logic [15:0] val);
    @(posedge ref_clk);
    load_val <= val;
    load     <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask : tload

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // read answers are matched against the oldest note
  always @(posedge ref_clk) begin : mon
    logic [63:0] q;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      q = exp_q.pop_front();
      chk(avs_readdata & q[63:32], q[31:0]);
    end
  end

  always @(posedge ref_clk) begin
    if (adc_go === 1'b1) go_n++;
    if (wide_timer_reset === 1'b1) rst_n++;
  end

  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    seed = 59; err_count = 0; n_compared = 0; go_n = 0; rst_n = 0;
    sys_rst = 1'b1; avs_address = 10'h000; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
    run = 1'b0; load = 1'b0; load_val = 16'h0000; ext_pin = 2'b00; adc_enabled = 1'b0;
    avs_byteenable = 4'hf;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(CH1_CTRL_IDX, 8'hff, CTRL_RESET);
    rd(CH2_CTRL_IDX, 8'hff, CTRL_RESET);
    rd(8'h30, 8'hff, 8'h00);
    avs_byteenable <= 4'he;
    wr(CH1_LOW_IDX, 8'h5a);
    avs_byteenable <= 4'hf;
    rd(CH1_LOW_IDX, 8'hff, 8'h00);
    wr(CH2_CTRL_IDX, 8'hff);
    rd(CH2_CTRL_IDX, 8'hff, {2'b00, CTRL_WMASK});
    wr(CH2_CTRL_IDX, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      nedge = (i == 3) ? 16 : (i == 2) ? 4 : i + 1;
      idle  = (i == 0);
      pin(idle);
      wr(CH1_CTRL_IDX, 8'h00);
      wr(CH1_CTRL_IDX, 8'h04 + 8'(i));
      wr(FLAGS_IDX, 8'h03);
      for (int k = 0; k < nedge; k++) begin
        v = $random(seed);
        tload(v[15:0]);
        if (k == nedge - 1 && i >= 2) rd(FLAGS_IDX, 8'h01, 8'h00);
        pin(~idle);
        pin(idle);
      end
      rd(CH1_LOW_IDX, 8'hff, v[7:0]);
      rd(CH1_HIGH_IDX, 8'hff, v[15:8]);
      rd(FLAGS_IDX, 8'h01, 8'h01);
    end
    wr(CH1_CTRL_IDX, 8'h05);
    wr(PORT_IDX, 8'h08);
    wr(FLAGS_IDX, 8'h03);
    v = $random(seed);
    tload(v[15:0]);
    wr(PORT_IDX, 8'h09);
    repeat (6) @(posedge ref_clk);
    rd(CH1_LOW_IDX, 8'hff, v[7:0]);
    rd(FLAGS_IDX, 8'h01, 8'h01);
    $display("test capture done");
    wr(CH1_CTRL_IDX, 8'h00);
    wr(PORT_IDX, 8'h08);
    wr(CH1_LOW_IDX, 8'h30);
    wr(CH1_HIGH_IDX, 8'h00);
    for (int i = 0; i < 4; i++) begin
      tload(16'h0000);
      wr(CH1_CTRL_IDX, {4'h0, cmp_mode[i]});
      wr(FLAGS_IDX, 8'h03);
      run <= 1'b1;
      repeat (80) @(posedge ref_clk);
      run <= 1'b0;
      rd(STATUS_IDX, 8'h01, {7'h0, cmp_mode[i] != DCCU_CMP_CLR});
      rd(FLAGS_IDX, 8'h01, 8'h01);
      chk(32'(channel_pin_out[0]), 32'(cmp_mode[i] != DCCU_CMP_CLR));
      chk(32'(channel_flag[0]), 32'h1);
      chk(32'(channel_pin_oe_n), 32'h2);
    end
    wr(CH1_CTRL_IDX, 8'h00);
    rd(STATUS_IDX, 8'h01, 8'h00);
    $display("test compare done");
    for (int c = 0; c < 3; c++) begin
      wr(c > 0 ? CH2_LOW_IDX : CH1_LOW_IDX, 8'h20);
      wr(c > 0 ? CH2_HIGH_IDX : CH1_HIGH_IDX, 8'h00);
      adc_enabled <= (c < 2);
      tload(16'h0000);
      wr(c > 0 ? CH2_CTRL_IDX : CH1_CTRL_IDX, {4'h0, DCCU_CMP_TRIG});
      g0 = go_n;
      r0 = rst_n;
      run <= 1'b1;
      repeat (100) @(posedge ref_clk);
      run <= 1'b0;
      chk(32'(rst_n - r0 >= 2), 32'h1);
      chk(32'(go_n > g0), 32'(c == 1));
      chk(32'(wide_timer_count <= 16'h0021), 32'h1);
      wr(c > 0 ? CH2_CTRL_IDX : CH1_CTRL_IDX, 8'h00);
    end
    $display("test trigger done");
    results();
  end
endmodule : tb_dccu_top

bind dccu_top dccu_chk dccu_chk_i (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .avs_response, .wide_timer_tick, .adc_enabled,
  .wide_timer_reset, .adc_go, .channel_flag);

`default_nettype wire
